// ### design/ots_pkg.sv
// Constants, types and state layout for the OTP security subsystem.
// Assumes a single 10 MHz clock and an active-high asynchronous reset.
package ots_pkg;
  localparam int OTP_ROWS = 512;
  localparam int OTP_SECTORS = 4;
  localparam int OTP_WORDS = OTP_ROWS * OTP_SECTORS;
  localparam int OTP_AW = 11;
  localparam int SRAM_WORDS = 16384;
  localparam int SRAM_AW = 14;
  localparam logic [23:0] RID_ADDR = 24'h100200;
  localparam logic [23:0] RID_DATA = 24'h200100;
  localparam logic [23:0] RID_CTRL = 24'h100300;
  localparam int CTRL_PROG = 0;
  localparam int CTRL_SECW = 1;
  localparam int SB_JTAG_OFF = 0;
  localparam int SB_LINK_OFF = 1;
  localparam int SB_SBOOT = 5;
  localparam int SB_REDUN = 7;
  localparam int SB_LOCK0 = 8;
  localparam int SB_MLOCK = 12;
  localparam int SB_JOTP_OFF = 13;
  localparam int SB_GP_LO = 15;
  localparam int SB_GP_HI = 21;
  localparam int SB_UID_LO = 22;
  localparam int SB_UID_HI = 31;
  localparam int UC_REV_W = 16;
  localparam logic [31:0] SEC_RST = 32'h00000000;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  typedef enum logic [2:0] {PH_LOCK = 3'h0, PH_LOAD = 3'h1, PH_COPY = 3'h3, PH_RUN = 3'h2,
    PH_WAITJ = 3'h6} ots_phase_t;
  typedef enum logic [2:0] {BS_NONE = 3'h0, BS_RSVD = 3'h1, BS_LINK = 3'h2, BS_SPI = 3'h3,
    BS_OTP = 3'h4} ots_boot_t;
  typedef enum logic [1:0] {JS_BYPASS = 2'h0, JS_ID = 2'h1, JS_UC = 2'h2, JS_BSCAN = 2'h3} ots_jsel_t;
  typedef struct packed {
    logic valid;
    logic we;
    logic [1:0] size;
    logic [15:0] addr;
    logic [31:0] wdata;
  } ots_mreq_t;
  typedef struct packed {
    logic valid;
    logic [23:0] id;
    logic [31:0] data;
  } ots_pwr_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [OTP_AW-1:0] addr;
    logic [31:0] wdata;
  } ots_jreq_t;
  typedef struct packed {
    ots_phase_t ph;
    logic [OTP_AW-1:0] cnt;
    logic [31:0] sec;
    logic [15:0] paddr;
    logic [31:0] pdata;
    ots_boot_t boot;
    logic run;
    logic jen;
    logic grant;
    logic deny;
    logic refused;
    logic [31:0] jsh;
    logic tdo;
    logic [31:0] jrd;
    logic jack;
    logic jdeny;
    logic [31:0] crd;
    logic cack;
  } ots_st_t;
  localparam ots_st_t ST_RST = '{ph: PH_LOCK, boot: BS_NONE, sec: SEC_RST, default: '0};
endpackage

// ### design/ots_top.sv
// OTP store, security configuration, boot sequencing, SRAM and test-chain registers.
// Assumes inputs synchronous to mclk and pll_lock driven by the clock generator.
`timescale 1ns/1ps
// Overview of operation
// - OTP: four sectors of 512 32-bit rows
// - Power up loads security word from OTP
// - OTP contents copied to SRAM, run first
// - Address, data, control programming ports by ID
// - Bit 0 disables test-access interface
// - Bit 1 refuses other tiles' access
// - Bit 5 forces boot from OTP address 0
// - Bit 7 enables redundant OTP rows
// - Bits 8-11 lock sectors 0-3
// - Bit 12 blocks all OTP programming
// - Bit 13 denies test-port OTP access
// - Bits 21:15 readable general-purpose field
// - User code: user ID, unused, revision
// - SRAM byte/half/word access in one cycle
// - Chain holds boundary-scan and chip controllers
// - Boundary-scan controller captures I/O pins
// - ID word: version, part, maker, bit0 one
// - Active-high reset; wait PLL lock, boot
// - Mode pins pick boot source otherwise
module ots_top
  import ots_pkg::*;
#(
  parameter logic [3:0] ID_VERSION = 4'h0, // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h0A5C, // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h155, // Arbitrary value
  parameter logic [UC_REV_W-1:0] UC_REV = 16'h0001 // Arbitrary value
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pll_lock,
  input wire logic [1:0] mode_boot,
  input wire ots_pwr_t pwr,
  input wire ots_jreq_t jreq,
  input wire ots_mreq_t cpu,
  input wire logic link_req,
  input wire logic jt_boot,
  input wire logic trst_n,
  input wire ots_jsel_t jt_sel,
  input wire logic jt_capture,
  input wire logic jt_shift,
  input wire logic jt_tdi,
  input wire logic [15:0] io_pins,
  output logic [31:0] sec_cfg,
  output logic [6:0] sec_gp,
  output logic redun_en,
  output logic jtag_en,
  output ots_boot_t boot_src,
  output logic cpu_run,
  output logic [31:0] cpu_rdata,
  output logic cpu_ack,
  output logic link_grant,
  output logic link_deny,
  output logic prog_refused,
  output logic [31:0] jt_otp_rdata,
  output logic jt_otp_ack,
  output logic jt_otp_deny,
  output logic jt_tdo
);
  ots_st_t s_r;
  ots_st_t s_nxt;
  // Blank OTP reads as zero
  logic [31:0] otp_mem [OTP_WORDS] = '{default: '0};
  logic [31:0] otp_sec_q = '0;
  logic [31:0] sram_mem [SRAM_WORDS];
  logic otp_we;
  logic [OTP_AW-1:0] otp_wa;
  logic [31:0] otp_wd;
  logic sec_we;
  logic [31:0] sec_wd;
  logic sram_we;
  logic [SRAM_AW-1:0] sram_wa;
  logic [31:0] sram_wd;
  logic [3:0] sram_be;
  logic [31:0] id_word;
  logic [31:0] uc_word;

  // Programming allowed only without master lock; OTP row writes also need an unlocked sector
  function automatic logic prog_ok(input logic [31:0] sec, input logic secw, input logic [15:0] a);
    logic [1:0] sect;
    sect = a[OTP_AW-1:OTP_AW-2];
    if (sec[SB_MLOCK]) begin
      prog_ok = 1'b0;
    end else if (secw) begin
      prog_ok = 1'b1;
    end else begin
      prog_ok = (a[15:OTP_AW] == '0) && !sec[SB_LOCK0 + 32'(sect)];
    end
  endfunction

  function automatic logic [3:0] be_of(input logic [1:0] sz, input logic [1:0] off);
    if (sz == SZ_BYTE) begin
      be_of = 4'h1 << off;
    end else if (sz == SZ_HALF) begin
      be_of = 4'h3 << {off[1], 1'b0};
    end else begin
      be_of = 4'hF;
    end
  endfunction

  function automatic logic [31:0] rd_align(input logic [31:0] w, input logic [1:0] sz, input logic [1:0] off);
    logic [31:0] t;
    t = w >> {off, 3'h0};
    if (sz == SZ_BYTE) begin
      rd_align = {24'h0, t[7:0]};
    end else if (sz == SZ_HALF) begin
      rd_align = {16'h0, t[15:0]};
    end else begin
      rd_align = w;
    end
  endfunction

  assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign uc_word = {s_r.sec[SB_UID_HI:SB_UID_LO], 6'h00, UC_REV};

  always_comb begin
    s_nxt = s_r;
    s_nxt.grant = 1'b0;
    s_nxt.deny = 1'b0;
    s_nxt.refused = 1'b0;
    s_nxt.jack = 1'b0;
    s_nxt.jdeny = 1'b0;
    s_nxt.cack = 1'b0;
    otp_we = 1'b0;
    otp_wa = '0;
    otp_wd = '0;
    sec_we = 1'b0;
    sec_wd = '0;
    sram_we = 1'b0;
    sram_wa = '0;
    sram_wd = '0;
    sram_be = '0;
    // Programming ports
    if (pwr.valid && pwr.id == RID_ADDR) begin
      s_nxt.paddr = pwr.data[15:0];
    end
    if (pwr.valid && pwr.id == RID_DATA) begin
      s_nxt.pdata = pwr.data;
    end
    if (pwr.valid && pwr.id == RID_CTRL && pwr.data[CTRL_PROG]) begin
      if (!prog_ok(s_r.sec, pwr.data[CTRL_SECW], s_r.paddr)) begin
        s_nxt.refused = 1'b1;
      end else if (pwr.data[CTRL_SECW]) begin
        sec_we = 1'b1;
        sec_wd = otp_sec_q | s_r.pdata;
      end else begin
        otp_we = 1'b1;
        otp_wa = s_r.paddr[OTP_AW-1:0];
        otp_wd = otp_mem[otp_wa] | s_r.pdata;
      end
    end
    // Test-port OTP access
    if (jreq.req) begin
      if (!s_r.jen || s_r.sec[SB_JOTP_OFF]) begin
        s_nxt.jdeny = 1'b1;
      end else if (!jreq.we) begin
        s_nxt.jrd = otp_mem[jreq.addr];
        s_nxt.jack = 1'b1;
      end else if (!otp_we && !sec_we && prog_ok(s_r.sec, 1'b0, 16'(jreq.addr))) begin
        otp_we = 1'b1;
        otp_wa = jreq.addr;
        otp_wd = otp_mem[jreq.addr] | jreq.wdata;
        s_nxt.jack = 1'b1;
      end else begin
        s_nxt.jdeny = 1'b1;
      end
    end
    // Boot sequencing
    unique case (s_r.ph)
      PH_LOCK: begin
        if (pll_lock) begin
          s_nxt.ph = PH_LOAD;
        end
      end
      PH_LOAD: begin
        s_nxt.sec = otp_sec_q;
        s_nxt.cnt = '0;
        s_nxt.ph = PH_COPY;
      end
      PH_COPY: begin
        sram_we = 1'b1;
        sram_wa = SRAM_AW'(s_r.cnt);
        sram_wd = otp_mem[s_r.cnt];
        sram_be = 4'hF;
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == OTP_AW'(OTP_WORDS - 1)) begin
          if (s_r.sec[SB_SBOOT]) begin
            s_nxt.boot = BS_OTP;
          end else begin
            s_nxt.boot = ots_boot_t'({1'b0, mode_boot});
          end
          if (s_r.sec[SB_SBOOT] || mode_boot[1]) begin
            s_nxt.ph = PH_RUN;
            s_nxt.run = 1'b1;
          end else begin
            s_nxt.ph = PH_WAITJ;
          end
        end
      end
      PH_WAITJ: begin
        if (jt_boot && s_r.jen) begin
          s_nxt.ph = PH_RUN;
          s_nxt.run = 1'b1;
        end
      end
      PH_RUN: begin
        if (cpu.valid) begin
          s_nxt.cack = 1'b1;
          if (cpu.we) begin
            sram_we = 1'b1;
            sram_wa = cpu.addr[15:2];
            sram_be = be_of(cpu.size, cpu.addr[1:0]);
            sram_wd = (cpu.size == SZ_BYTE) ? {4{cpu.wdata[7:0]}} :
                      (cpu.size == SZ_HALF) ? {2{cpu.wdata[15:0]}} : cpu.wdata;
          end else begin
            s_nxt.crd = rd_align(sram_mem[cpu.addr[15:2]], cpu.size, cpu.addr[1:0]);
          end
        end
      end
      default: begin
        s_nxt.ph = PH_LOCK;
      end
    endcase
    // Inter-tile access
    if (link_req) begin
      if (s_r.sec[SB_LINK_OFF]) begin
        s_nxt.deny = 1'b1;
      end else begin
        s_nxt.grant = 1'b1;
      end
    end
    // Test port enable, held off until the security word is known
    s_nxt.jen = trst_n && !s_r.sec[SB_JTAG_OFF] && s_r.ph != PH_LOCK && s_r.ph != PH_LOAD;
    // Chain: chip controller registers and boundary-scan capture
    if (!s_r.jen) begin
      s_nxt.jsh = '0;
      s_nxt.tdo = 1'b0;
    end else if (jt_capture) begin
      unique case (jt_sel)
        JS_ID: s_nxt.jsh = id_word;
        JS_UC: s_nxt.jsh = uc_word;
        JS_BSCAN: s_nxt.jsh = {16'h0000, io_pins};
        JS_BYPASS: s_nxt.jsh = '0;
      endcase
    end else if (jt_shift) begin
      s_nxt.tdo = s_r.jsh[0];
      s_nxt.jsh = {jt_tdi, s_r.jsh[31:1]};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // OTP store: bits only ever set
  always_ff @(posedge mclk) begin
    if (otp_we) begin
      otp_mem[otp_wa] <= otp_wd;
    end
    if (sec_we) begin
      otp_sec_q <= sec_wd;
    end
  end

  always_ff @(posedge mclk) begin
    if (sram_we) begin
      for (int b = 0; b < 4; b++) begin
        if (sram_be[b]) begin
          sram_mem[sram_wa][8*b +: 8] <= sram_wd[8*b +: 8];
        end
      end
    end
  end

  assign sec_cfg = s_r.sec;
  assign sec_gp = s_r.sec[SB_GP_HI:SB_GP_LO];
  assign redun_en = s_r.sec[SB_REDUN];
  assign jtag_en = s_r.jen;
  assign boot_src = s_r.boot;
  assign cpu_run = s_r.run;
  assign cpu_rdata = s_r.crd;
  assign cpu_ack = s_r.cack;
  assign link_grant = s_r.grant;
  assign link_deny = s_r.deny;
  assign prog_refused = s_r.refused;
  assign jt_otp_rdata = s_r.jrd;
  assign jt_otp_ack = s_r.jack;
  assign jt_otp_deny = s_r.jdeny;
  assign jt_tdo = s_r.tdo;

  property p_jtag_off;
    @(posedge mclk) disable iff (rst) s_r.sec[SB_JTAG_OFF] |=> !jtag_en;
  endproperty
  a_jtag_off: assert property (p_jtag_off) else $error("test port active while disabled");

  property p_link_deny;
    @(posedge mclk) disable iff (rst) link_req && s_r.sec[SB_LINK_OFF] |=> link_deny && !link_grant;
  endproperty
  a_link_deny: assert property (p_link_deny) else $error("tile access not refused");

  property p_mlock;
    @(posedge mclk) disable iff (rst)
      pwr.valid && pwr.id == RID_CTRL && pwr.data[CTRL_PROG] && s_r.sec[SB_MLOCK] |=> prog_refused;
  endproperty
  a_mlock: assert property (p_mlock) else $error("program accepted under master lock");

  property p_sector_lock;
    @(posedge mclk) disable iff (rst)
      otp_we |-> !s_r.sec[SB_LOCK0 + 32'(otp_wa[OTP_AW-1:OTP_AW-2])] && !s_r.sec[SB_MLOCK];
  endproperty
  a_sector_lock: assert property (p_sector_lock) else $error("locked sector written");

  property p_jotp;
    @(posedge mclk) disable iff (rst) jreq.req && s_r.sec[SB_JOTP_OFF] |=> jt_otp_deny && !jt_otp_ack;
  endproperty
  a_jotp: assert property (p_jotp) else $error("test port reached OTP");

  property p_sram_ack;
    @(posedge mclk) disable iff (rst) cpu.valid && s_r.ph == PH_RUN |=> cpu_ack;
  endproperty
  a_sram_ack: assert property (p_sram_ack) else $error("SRAM access not done in one cycle");

  property p_wait_lock;
    @(posedge mclk) disable iff (rst) s_r.ph == PH_LOCK && !pll_lock |=> s_r.ph == PH_LOCK && !cpu_run;
  endproperty
  a_wait_lock: assert property (p_wait_lock) else $error("boot left before PLL lock");

  property p_sec_load;
    @(posedge mclk) disable iff (rst) s_r.ph == PH_LOAD |=> sec_cfg == $past(otp_sec_q) ##1 s_r.ph == PH_COPY;
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("security word not loaded");

  property p_secure_boot;
    @(posedge mclk) disable iff (rst) $rose(cpu_run) && s_r.sec[SB_SBOOT] |-> boot_src == BS_OTP;
  endproperty
  a_secure_boot: assert property (p_secure_boot) else $error("secure boot not from OTP");

  property p_device_identification;
    @(posedge mclk) disable iff (rst) jtag_en && jt_capture && jt_sel == JS_ID ##1 jtag_en && jt_shift
      |=> jt_tdo;
  endproperty
  a_device_identification: assert property (p_device_identification) else $error("identification bit 0 not one");

  property p_usercode;
    @(posedge mclk) disable iff (rst) jtag_en && jt_capture && jt_sel == JS_UC
      |=> s_r.jsh[31:22] == $past(s_r.sec[SB_UID_HI:SB_UID_LO]);
  endproperty
  a_usercode: assert property (p_usercode) else $error("user ID field wrong");

  c_run: cover property (@(posedge mclk) disable iff (rst) $rose(cpu_run));
  c_refused: cover property (@(posedge mclk) disable iff (rst) prog_refused);
  c_waitj: cover property (@(posedge mclk) disable iff (rst) s_r.ph == PH_WAITJ ##1 s_r.ph == PH_RUN);
endmodule

// ### dv/ots_host.sv
// Test-port host and OTP programming software model.
// Assumes mclk from the bench; drives just after the falling edge.
`timescale 1ns/1ps
module ots_host
  import ots_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic prog_refused,
  input wire logic jt_otp_ack,
  input wire logic jt_otp_deny,
  input wire logic [31:0] jt_otp_rdata,
  output ots_pwr_t pwr,
  output ots_jreq_t jreq,
  output logic trst_n
);
  // Test reset follows chip reset, released two cycles later
  initial begin
    pwr = '0;
    jreq = '0;
    trst_n = 1'b0;
    forever begin
      @(negedge rst);
      repeat (2) @(negedge mclk);
      trst_n <= 1'b1;
      @(posedge rst);
      trst_n <= 1'b0;
    end
  end
  task automatic put(input logic [23:0] id, input logic [31:0] d);
    @(negedge mclk);
    pwr <= '{valid: 1'b1, id: id, data: d};
    @(negedge mclk);
    pwr <= '0;
  endtask
  // Address, then data, then control; reports a refusal
  task automatic prog(input logic [15:0] a, input logic [31:0] d, input logic sw, output logic rf);
    put(RID_ADDR, {16'h0000, a});
    put(RID_DATA, d);
    @(negedge mclk);
    pwr <= '{valid: 1'b1, id: RID_CTRL, data: {30'h0, sw, 1'b1}};
    rf = 1'b0;
    repeat (3) begin
      @(negedge mclk);
      pwr <= '0;
      rf = rf | (prog_refused === 1'b1);
    end
  endtask
  task automatic jrd(input logic [10:0] a, output logic [1:0] ad, output logic [31:0] d);
    @(negedge mclk);
    jreq <= '{req: 1'b1, we: 1'b0, addr: a, wdata: 32'h0};
    ad = 2'h0;
    d = 'x;
    repeat (2) begin
      @(negedge mclk);
      jreq <= '0;
      if (jt_otp_ack === 1'b1) begin
        ad[1] = 1'b1;
        d = jt_otp_rdata;
      end
      ad[0] = ad[0] | (jt_otp_deny === 1'b1);
    end
  endtask
  // Test-port OTP write; reports ack and deny
  task automatic jwr(input logic [10:0] a, input logic [31:0] d, output logic [1:0] ad);
    @(negedge mclk);
    jreq <= '{req: 1'b1, we: 1'b1, addr: a, wdata: d};
    ad = 2'h0;
    repeat (2) begin
      @(negedge mclk);
      jreq <= '0;
      ad = ad | {jt_otp_ack === 1'b1, jt_otp_deny === 1'b1};
    end
  endtask
endmodule

// ### dv/tb_ots_top.sv
// Self-checking bench for the OTP security block.
// Assumes ots_host drives the port-write, test-port request and test reset.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_ots_top
  import ots_pkg::*;
;
  localparam logic [3:0] VER = 4'h3; // Arbitrary value
  localparam logic [15:0] PART = 16'h1234; // Arbitrary value
  localparam logic [10:0] MAKER = 11'h2AB; // Arbitrary value
  localparam logic [15:0] REV = 16'h00C5; // Arbitrary value
  localparam logic [31:0] S1 = 32'hB0AA_81A2;
  localparam logic [31:0] S2 = 32'h0000_3001;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pll_lock = 1'b0;
  logic [1:0] mode_boot = 2'h0;
  ots_pwr_t pwr;
  ots_jreq_t jreq;
  ots_mreq_t cpu = '0;
  logic link_req = 1'b0;
  logic jt_boot = 1'b0;
  logic trst_n;
  ots_jsel_t jt_sel = JS_BYPASS;
  logic jt_capture = 1'b0;
  logic jt_shift = 1'b0;
  logic [31:0] sec_cfg, cpu_rdata, jt_otp_rdata, w;
  logic [6:0] sec_gp;
  ots_boot_t boot_src;
  logic redun_en, jtag_en, cpu_run, cpu_ack, link_grant, link_deny;
  logic prog_refused, jt_otp_ack, jt_otp_deny, jt_tdo, rf;
  logic [1:0] ad;
  int errors = 0;
  int checked = 0;
  always #50 mclk = ~mclk;
  ots_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER), .UC_REV(REV)) u_dut (
    .mclk(mclk), .rst(rst), .pll_lock(pll_lock), .mode_boot(mode_boot), .pwr(pwr), .jreq(jreq),
    .cpu(cpu), .link_req(link_req), .jt_boot(jt_boot), .trst_n(trst_n), .jt_sel(jt_sel),
    .jt_capture(jt_capture), .jt_shift(jt_shift), .jt_tdi(1'b1), .io_pins(16'hC3A5),
    .sec_cfg(sec_cfg), .sec_gp(sec_gp), .redun_en(redun_en), .jtag_en(jtag_en), .boot_src(boot_src),
    .cpu_run(cpu_run), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .link_grant(link_grant),
    .link_deny(link_deny), .prog_refused(prog_refused), .jt_otp_rdata(jt_otp_rdata),
    .jt_otp_ack(jt_otp_ack), .jt_otp_deny(jt_otp_deny), .jt_tdo(jt_tdo));
  ots_host u_host (
    .mclk(mclk), .rst(rst), .prog_refused(prog_refused), .jt_otp_ack(jt_otp_ack),
    .jt_otp_deny(jt_otp_deny), .jt_otp_rdata(jt_otp_rdata), .pwr(pwr), .jreq(jreq), .trst_n(trst_n));
  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic boot(input logic [1:0] m);
    int n;
    @(negedge mclk);
    rst <= 1'b1;
    pll_lock <= 1'b0;
    mode_boot <= m;
    repeat (20) @(negedge mclk);
    rst <= 1'b0;
    repeat (4) @(negedge mclk);
    `CHK("run before lock", 1'b0, cpu_run)
    pll_lock <= 1'b1;
    n = 0;
    while (cpu_run !== 1'b1 && n < 2300) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic mem(input logic we, input logic [1:0] sz, input logic [15:0] a, input logic [31:0] wd);
    @(negedge mclk);
    cpu <= '{valid: 1'b1, we: we, size: sz, addr: a, wdata: wd};
    w = 'x;
    repeat (2) begin
      @(negedge mclk);
      cpu <= '0;
      if (cpu_ack === 1'b1) w = cpu_rdata;
    end
  endtask
  task automatic scan(input ots_jsel_t s);
    @(negedge mclk);
    jt_sel <= s;
    jt_capture <= 1'b1;
    @(negedge mclk);
    jt_capture <= 1'b0;
    jt_shift <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(negedge mclk);
      w[i] = jt_tdo;
    end
    jt_shift <= 1'b0;
  endtask
  task automatic link(output logic g, output logic d);
    @(negedge mclk);
    link_req <= 1'b1;
    @(negedge mclk);
    link_req <= 1'b0;
    g = link_grant;
    d = link_deny;
  endtask
  task automatic t_modes();
    boot(2'h3);
    `CHK("src spi", BS_SPI, boot_src)
    `CHK("spi run", 1'b1, cpu_run)
    `CHK("redun off", 1'b0, redun_en)
    boot(2'h2);
    `CHK("src link", BS_LINK, boot_src)
    `CHK("link run", 1'b1, cpu_run)
    boot(2'h1);
    `CHK("src rsvd", BS_RSVD, boot_src)
    `CHK("rsvd wait", 1'b0, cpu_run)
    $display("test modes done");
  endtask
  task automatic t_blank();
    logic g, d;
    boot(2'h0);
    `CHK("blank sec", 32'h0, sec_cfg)
    `CHK("src none", BS_NONE, boot_src)
    `CHK("wait test port", 1'b0, cpu_run)
    `CHK("jtag on", 1'b1, jtag_en)
    @(negedge mclk);
    jt_boot <= 1'b1;
    @(negedge mclk);
    jt_boot <= 1'b0;
    repeat (3) @(negedge mclk);
    `CHK("run after jt_boot", 1'b1, cpu_run)
    link(g, d);
    `CHK("grant", 2'b10, {g, d})
    scan(JS_ID);
    `CHK("device_identification", {VER, PART, MAKER, 1'b1}, w)
    scan(JS_UC);
    `CHK("usercode blank", {16'h0, REV}, w)
    scan(JS_BSCAN);
    `CHK("bscan", {16'h0000, 16'hC3A5}, w)
    mem(1'b1, 2'h2, 16'h0010, 32'h1122_3344);
    mem(1'b0, SZ_BYTE, 16'h0011, 32'h0);
    `CHK("byte rd", 32'h0000_0033, w)
    mem(1'b0, SZ_HALF, 16'h0012, 32'h0);
    `CHK("half rd", 32'h0000_1122, w)
    mem(1'b1, SZ_BYTE, 16'h0013, 32'h0000_00AB);
    mem(1'b0, 2'h2, 16'h0010, 32'h0);
    `CHK("word rd", 32'hAB22_3344, w)
    u_host.prog(16'h0205, 32'hA5A5_0001, 1'b0, rf);
    `CHK("prog ok", 1'b0, rf)
    u_host.jrd(11'h205, ad, w);
    `CHK("otp rd", {2'b10, 32'hA5A5_0001}, {ad, w})
    u_host.prog(16'h0000, S1, 1'b1, rf);
    `CHK("sec prog ok", 1'b0, rf)
    $display("test blank done");
  endtask
  task automatic t_secure();
    logic g, d;
    boot(2'h2);
    `CHK("sec load", S1, sec_cfg)
    `CHK("gp", 7'h55, sec_gp)
    `CHK("redun", 1'b1, redun_en)
    `CHK("src otp", BS_OTP, boot_src)
    `CHK("run", 1'b1, cpu_run)
    mem(1'b0, 2'h2, 16'h0814, 32'h0);
    `CHK("copied", 32'hA5A5_0001, w)
    link(g, d);
    `CHK("deny", 2'b01, {g, d})
    scan(JS_UC);
    `CHK("usercode", {10'h2C2, 6'h0, REV}, w)
    u_host.prog(16'h0003, 32'h0000_00FF, 1'b0, rf);
    `CHK("sector0 refused", 1'b1, rf)
    u_host.jwr(11'h003, 32'h0000_000F, ad);
    `CHK("jt sector0 deny", 2'b01, ad)
    u_host.jrd(11'h003, ad, w);
    `CHK("sector0 kept", {2'b10, 32'h0}, {ad, w})
    u_host.prog(16'h0403, 32'h0000_0005, 1'b0, rf);
    `CHK("sector2 ok", 1'b0, rf)
    u_host.jwr(11'h403, 32'h0000_0030, ad);
    `CHK("jt sector2 ok", 2'b10, ad)
    u_host.jrd(11'h403, ad, w);
    `CHK("sector2 word", {2'b10, 32'h0000_0035}, {ad, w})
    u_host.prog(16'h0000, S2, 1'b1, rf);
    `CHK("lock prog ok", 1'b0, rf)
    $display("test secure done");
  endtask
  task automatic t_locked();
    boot(2'h3);
    `CHK("sec merged", S1 | S2, sec_cfg)
    `CHK("jtag off", 1'b0, jtag_en)
    u_host.jrd(11'h403, ad, w);
    `CHK("jt otp deny", 2'b01, ad)
    u_host.jwr(11'h403, 32'h0000_0001, ad);
    `CHK("jt otp wr deny", 2'b01, ad)
    u_host.prog(16'h0600, 32'h0000_0001, 1'b0, rf);
    `CHK("master lock", 1'b1, rf)
    $display("test locked done");
  endtask
  initial begin
    t_modes();
    t_blank();
    t_secure();
    t_locked();
    results();
  end
  // Six boots of about 2300 cycles each, with margin
  initial begin
    #3000000;
    errors++;
    results();
  end
endmodule
